//--- hdl/rcb_params.svh
// Constants for the registered command buffer with parity check
`ifndef RCB_PARAMS_SVH
`define RCB_PARAMS_SVH

`define RCB_DATA_W 25
`define RCB_HALF_W 14
`define RCB_UPPER_W 11
`define RCB_MASK_1TO1 25'h1FFFFB6
`define RCB_MASK_FRONT 25'h0003FB6
`define RCB_MASK_BACK 25'h0001BBF
`define RCB_MASK_NONE 25'h0000000
`define RCB_ERR_HOLD_CYC 2
`define RCB_RST_DATA 25'h0000000
`define RCB_RST_PAIR 2'h0
`define RCB_RST_ERR_N 1'h1

`endif

//--- hdl/rcb_pkg.sv
// Types for the registered command buffer with parity check
`default_nettype none
package rcb_pkg;
  typedef enum logic [1:0] {
    RCB_MODE_1TO1,
    RCB_MODE_FRONT,
    RCB_MODE_RESERVED,
    RCB_MODE_BACK
  } rcb_mode_e;
endpackage
`default_nettype wire

//--- hdl/rcb_parity.sv
// Mode decode and parity reduction over the selected data inputs
`include "rcb_params.svh"
`default_nettype none
module rcb_parity (
  input wire logic [25:1] data_i,
  input wire logic side_select_strap_i,
  input wire logic width_select_strap_i,
  output var rcb_pkg::rcb_mode_e mode_o,
  output logic sel_xor_o
);
  logic [25:1] mask;

  always_comb
  begin
    mode_o = rcb_pkg::rcb_mode_e'({side_select_strap_i, width_select_strap_i});
    mask = `RCB_MASK_NONE;
    unique case (mode_o)
      rcb_pkg::RCB_MODE_1TO1: mask = `RCB_MASK_1TO1;
      rcb_pkg::RCB_MODE_FRONT: mask = `RCB_MASK_FRONT;
      rcb_pkg::RCB_MODE_BACK: mask = `RCB_MASK_BACK;
      rcb_pkg::RCB_MODE_RESERVED: mask = `RCB_MASK_NONE;
    endcase
    sel_xor_o = ^(data_i & mask);
  end
endmodule // rcb_parity
`default_nettype wire

//--- hdl/rcb_top.sv
// Registered command buffer with chip-select gating and parity check
`include "rcb_params.svh"
`default_nettype none
// Functional notes
// - Each rising edge registers control inputs, and data unless both selects high
// - Between clock edges outputs change only on reset
// - Both selects high freezes data, parity, error
// - Parity out is odd count; error low if odd
// - Parity input lags one or two cycles
// - Error asserts from released, stays low two cycles
// - Reset forces outputs low, error released
// - Mode 00 checks bits 2,3,5,6,8-25
// - Mode 01 checks bits 2,3,5,6,8-14
// - Mode 11 checks bits 1-6,8-10,12,13
// - Straps choose one-to-one, front, back or reserved (mode 10, no bits checked)
// - Error appears one cycle after its data, two with side strap high
module rcb_top (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [25:1] data_in_i,
  input wire logic term_enable_in_i,
  input wire logic clk_enable_in_i,
  input wire logic primary_chip_select_n_i,
  input wire logic secondary_chip_select_n_i,
  input wire logic parity_in_i,
  input wire logic side_select_strap_i,
  input wire logic width_select_strap_i,
  output logic [25:1] data_out_o,
  output logic [14:1] data_copy_out_o,
  output logic [1:0] term_enable_out_o,
  output logic [1:0] clk_enable_out_o,
  output logic [1:0] chip_select_copy_out_o,
  output logic partial_parity_out_o,
  output logic parity_error_n_o,
  output logic parity_error_oe_o
);
  rcb_pkg::rcb_mode_e mode;
  logic sel_xor;
  logic both_high;
  logic one_to_one;
  logic stage1;
  logic stage2;
  logic hold_cnt;
  logic [25:1] next_data_out;
  logic [14:1] next_data_copy;
  logic [1:0] next_term;
  logic [1:0] next_cke;
  logic [1:0] next_cs;
  logic next_stage1;
  logic next_stage2;
  logic next_ppo;
  logic next_err_n;
  logic next_hold_cnt;
  logic odd;

  rcb_parity u_parity (
    .data_i(data_in_i),
    .side_select_strap_i(side_select_strap_i),
    .width_select_strap_i(width_select_strap_i),
    .mode_o(mode),
    .sel_xor_o(sel_xor)
  );

  assign both_high = primary_chip_select_n_i & secondary_chip_select_n_i;
  assign one_to_one = (mode == rcb_pkg::RCB_MODE_1TO1);

  always_comb
  begin
    next_data_out = data_out_o;
    next_data_copy = data_copy_out_o;
    if (!both_high)
    begin
      if (one_to_one)
      begin
        next_data_out = data_in_i;
        next_data_copy = 14'h0000;
      end
      else
      begin
        next_data_out = {`RCB_UPPER_W'(0), data_in_i[14:1]};
        next_data_copy = data_in_i[14:1];
      end
    end
    next_term = one_to_one ? {1'h0, term_enable_in_i} : {2{term_enable_in_i}};
    next_cke = one_to_one ? {1'h0, clk_enable_in_i} : {2{clk_enable_in_i}};
    next_cs = one_to_one ? {1'h0, primary_chip_select_n_i}
                         : {2{primary_chip_select_n_i}};
  end

  always_comb
  begin
    next_stage1 = sel_xor;
    next_stage2 = stage1;
    odd = (side_select_strap_i ? stage2 : stage1) ^ parity_in_i;
    next_ppo = partial_parity_out_o;
    next_err_n = parity_error_n_o;
    next_hold_cnt = hold_cnt;
    if (!both_high)
    begin
      next_ppo = odd;
      if (parity_error_n_o)
      begin
        next_err_n = ~odd;
        next_hold_cnt = odd;
      end
      else if (hold_cnt)
      begin
        next_hold_cnt = 1'h0;
      end
      else
      begin
        next_err_n = 1'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      data_out_o <= `RCB_RST_DATA;
      data_copy_out_o <= 14'h0000;
      term_enable_out_o <= `RCB_RST_PAIR;
      clk_enable_out_o <= `RCB_RST_PAIR;
      chip_select_copy_out_o <= `RCB_RST_PAIR;
      partial_parity_out_o <= 1'h0;
      parity_error_n_o <= `RCB_RST_ERR_N;
      parity_error_oe_o <= 1'h0;
      hold_cnt <= 1'h0;
      stage1 <= 1'h0;
      stage2 <= 1'h0;
    end
    else
    begin
      data_out_o <= next_data_out;
      data_copy_out_o <= next_data_copy;
      term_enable_out_o <= next_term;
      clk_enable_out_o <= next_cke;
      chip_select_copy_out_o <= next_cs;
      partial_parity_out_o <= next_ppo;
      parity_error_n_o <= next_err_n;
      parity_error_oe_o <= ~next_err_n;
      hold_cnt <= next_hold_cnt;
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  sequence s_err_low2;
    !parity_error_n_o [*2];
  endsequence

  sequence s_ungated;
    !(primary_chip_select_n_i && secondary_chip_select_n_i);
  endsequence

  property p_term_capture;
    @(posedge clock_i) disable iff (!rst_b_i)
    $past(rst_b_i) |-> term_enable_out_o[0] == $past(term_enable_in_i);
  endproperty
  a_term_capture: assert property (p_term_capture) else $error("term copy wrong");

  property p_cs_capture;
    @(posedge clock_i) disable iff (!rst_b_i)
    $past(rst_b_i) |-> chip_select_copy_out_o[0] == $past(primary_chip_select_n_i);
  endproperty
  a_cs_capture: assert property (p_cs_capture) else $error("cs copy wrong");

  property p_data_capture;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_ungated ##0 rst_b_i ##0 (mode == rcb_pkg::RCB_MODE_1TO1)
    |=> data_out_o == $past(data_in_i);
  endproperty
  a_data_capture: assert property (p_data_capture) else $error("data not captured");

  property p_copy_capture;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_ungated ##0 rst_b_i ##0 (mode != rcb_pkg::RCB_MODE_1TO1)
    |=> data_copy_out_o == $past(data_in_i[14:1]);
  endproperty
  a_copy_capture: assert property (p_copy_capture) else $error("copy not captured");

  property p_cke_capture;
    @(posedge clock_i) disable iff (!rst_b_i)
    $past(rst_b_i) |-> clk_enable_out_o[0] == $past(clk_enable_in_i);
  endproperty
  a_cke_capture: assert property (p_cke_capture) else $error("cke copy wrong");

  property p_freeze;
    @(posedge clock_i) disable iff (!rst_b_i)
    both_high |=> $stable(data_out_o) && $stable(partial_parity_out_o)
                  && $stable(parity_error_n_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("gated outputs moved");

  property p_ppo_lag1;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_ungated ##0 !side_select_strap_i ##0 $past(rst_b_i, 2)
    |=> partial_parity_out_o == ($past(sel_xor, 2) ^ $past(parity_in_i));
  endproperty
  a_ppo_lag1: assert property (p_ppo_lag1) else $error("parity lag one wrong");

  property p_ppo_lag2;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_ungated ##0 side_select_strap_i ##0 $past(rst_b_i, 3)
    |=> partial_parity_out_o == ($past(sel_xor, 3) ^ $past(parity_in_i));
  endproperty
  a_ppo_lag2: assert property (p_ppo_lag2) else $error("parity lag two wrong");

  property p_err_odd;
    @(posedge clock_i) disable iff (!rst_b_i)
    $fell(parity_error_n_o) |-> partial_parity_out_o && parity_error_oe_o;
  endproperty
  a_err_odd: assert property (p_err_odd) else $error("error without odd parity");

  property p_err_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
    $fell(parity_error_n_o) |-> s_err_low2;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error not held two cycles");

  property p_reset_out;
    @(posedge clock_i)
    !rst_b_i |-> data_out_o == `RCB_RST_DATA && parity_error_n_o && !partial_parity_out_o;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset values wrong");
endmodule // rcb_top
`default_nettype wire

//--- test/rcb_ctrl_model.sv
// Controller model driving parity one or two cycles behind its data
`default_nettype none
module rcb_ctrl_model (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [25:1] data_i,
  input wire logic [25:1] mask_i,
  input wire logic side_i,
  input wire logic flip_i,
  output logic parity_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held;
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      held <= 1'b0;
      parity_o <= 1'b0;
    end
    else
    begin
      held <= ^(data_i & mask_i) ^ flip_i;
      parity_o <= side_i ? held : ^(data_i & mask_i) ^ flip_i;
    end
  end
endmodule // rcb_ctrl_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the registered command buffer
`include "rcb_params.svh"
`default_nettype none
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("unexpected %0t: %h not %h", $time, g, e); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b1;
  logic [25:1] din = '0;
  logic term = 1'b0;
  logic cke = 1'b0;
  logic pcs_n = 1'b1;
  logic scs_n = 1'b1;
  logic side = 1'b0;
  logic width = 1'b0;
  logic flip = 1'b0;
  logic par;
  logic [25:1] dout, e_dout, mask;
  logic [14:1] dcopy, e_copy;
  logic [1:0] term_o, cke_o, cs_o, e_term, e_cke, e_cs;
  logic partial_parity_out, err_n, err_oe, e_ppo, e_err_n;
  logic [31:0] lfsr = 32'h14A1;
  bit q[$];
  bit old;
  int cnt, fails, tests_run;
  always #2 clk = ~clk;
  assign mask = width ? (side ? `RCB_MASK_BACK : `RCB_MASK_FRONT) : `RCB_MASK_1TO1;
  rcb_top i_dut (
    .clock_i(clk), .rst_b_i(rst_b), .data_in_i(din), .term_enable_in_i(term),
    .clk_enable_in_i(cke), .primary_chip_select_n_i(pcs_n),
    .secondary_chip_select_n_i(scs_n), .parity_in_i(par), .side_select_strap_i(side),
    .width_select_strap_i(width), .data_out_o(dout), .data_copy_out_o(dcopy),
    .term_enable_out_o(term_o), .clk_enable_out_o(cke_o), .chip_select_copy_out_o(cs_o),
    .partial_parity_out_o(partial_parity_out), .parity_error_n_o(err_n), .parity_error_oe_o(err_oe)
  );
  rcb_ctrl_model i_ctrl (
    .clock_i(clk), .rst_b_i(rst_b), .data_i(din), .mask_i(mask), .side_i(side),
    .flip_i(flip), .parity_o(par)
  );
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h00400007 : 32'h0);
  endfunction
  task automatic model_reset();
    e_dout = '0;
    e_copy = '0;
    e_term = '0;
    e_cke = '0;
    e_cs = '0;
    e_ppo = 1'b0;
    e_err_n = 1'b1;
    cnt = 0;
    q.delete();
    repeat (side ? 2 : 1) q.push_back(1'b0);
  endtask
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (rst_b)
    begin
      old = q.pop_front();
      q.push_back(^(din & mask));
      e_term = {width & term, term};
      e_cke = {width & cke, cke};
      e_cs = {width & pcs_n, pcs_n};
      if (!(pcs_n & scs_n))
      begin
        e_dout = width ? {11'h000, din[14:1]} : din;
        e_copy = width ? din[14:1] : 14'h0000;
        e_ppo = old ^ par;
        if (e_err_n)
          e_err_n = !e_ppo;
        else if (cnt == 1)
        begin
          e_err_n = 1'b1;
          cnt = 0;
        end
        else
          cnt = 1;
      end
    end
  end
  always @(negedge clk)
  begin
    if (!rst_b)
      model_reset();
    `CHK(dout, e_dout)
    `CHK(dcopy, e_copy)
    `CHK({term_o, cke_o, cs_o}, {e_term, e_cke, e_cs})
    `CHK(partial_parity_out, e_ppo)
    `CHK(err_n, e_err_n)
    `CHK(err_oe, !e_err_n)
  end
  always @(posedge clk)
  begin
    lfsr = next_rand(lfsr);
    din <= lfsr[24:0];
    pcs_n <= lfsr[25];
    scs_n <= lfsr[26];
    term <= lfsr[27];
    cke <= lfsr[28];
    flip <= lfsr[29] & lfsr[31];
  end
  initial
  begin
    rst_b <= 1'b0;
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clk);
      rst_b <= 1'b0;
      side <= (m == 2);
      width <= (m != 0);
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (500) @(posedge clk);
    end
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
